// ---- pkg/tmr_regs.svh ----
// Behaviour
// - Clear-on-match-A bit set: counter clears on compare match A, else free runs.
// - Clock select 000/001/010/011 counts every 1/2/4/8 system clocks.
// - Clock select 1XX counts rising edges of the external event input.
// - Select 000 counts subclock ticks while in sub-active or sub-sleep mode.
// - Level bit D drives compare pin D until the first match D.
// - Level bit C drives compare pin C until the first match C.
// - Level bit B drives compare pin B until the first match B.
// - Level bit A drives compare pin A until the first match A.
// - A write to a level bit reaches its pin at once.
// - Overflow enable gates the overflow interrupt request.
// - Enable D gates the match D interrupt request.
// - Enable C gates the match C interrupt request.
// - Enable B gates the match B interrupt request.
// - Enable A gates the match A interrupt request.
// - Enable register bits 6 to 4 ignore writes and read as one.
// - Overflow flag sets when the counter wraps from FFFF to 0000, except when that step is a clear on match A.
// - A flag clears only by reading it as one, then writing zero.
// - Match flag A sets when the counter equals general register A.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define ADDR_CONTROL 12'h000
`define ADDR_IRQ_ENABLE 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_COUNT 12'h00C
`define ADDR_GENERAL_A 12'h010
`define ADDR_GENERAL_B 12'h014
`define ADDR_GENERAL_C 12'h018
`define ADDR_GENERAL_D 12'h01C
`define CTRL_CLEAR_BIT 7
`define CTRL_CKS_HI 6
`define CTRL_CKS_LO 4
`define IE_OVF_BIT 7
`define IE_RSVD_BITS 8'h70
`define STAT_RSVD_BITS 8'h70
`define STAT_OVF_BIT 7
`define CONTROL_RESET 8'h00
`define IE_RESET 8'h00
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define GENERAL_RESET 16'hFFFF
`define DIV_MAX 3'h7
`endif

// ---- pkg/tmr_pkg.sv ----
package tmr_pkg;
   typedef enum logic [2:0] {
      SEL_DIV1 = 3'h0,
      SEL_DIV2 = 3'h1,
      SEL_DIV4 = 3'h2,
      SEL_DIV8 = 3'h3
   } clk_sel_t;
endpackage

// ---- logic/timer_core.sv ----
`timescale 1ns/1ps
`include "tmr_regs.svh"
module timer_core (
   input wire logic pclk, // APB clock, 20 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic external_event_in, // External count event pin
   input wire logic subclock_in, // Subclock pin
   input wire logic low_power_mode, // Sub-active or sub-sleep mode
   output logic [3:0] compare_pin, // Compare outputs D..A as [3:0]
   output logic overflow_irq, // Overflow request
   output logic [3:0] match_irq // Match requests D..A as [3:0]
);
   // ****************************************************************
   // Registers and synchronisers
   // ****************************************************************
   logic [7:0] timer_control;
   logic [7:0] timer_interrupt_enable;
   logic [4:0] timer_status; // [4] overflow, [3:0] match D..A
   logic [4:0] flag_seen;
   logic [15:0] count_value;
   logic [15:0] general_reg [4];
   logic [3:0] matched_once;
   logic [2:0] div_count;
   logic [2:0] ev_sync;
   logic [2:0] sub_sync;
   logic [1:0] lp_sync;
   logic count_tick;
   logic [3:0] match_now;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] next_prdata;
   logic [3:0] next_pin;

   function automatic logic tick_of(input logic [2:0] sel, input logic [2:0] div);
      unique case (sel[1:0])
         2'h0: tick_of = 1'b1;
         2'h1: tick_of = div[0];
         2'h2: tick_of = &div[1:0];
         default: tick_of = &div;
      endcase
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr <= `ADDR_GENERAL_D) && (paddr[1:0] == 2'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_sync <= 3'h0;
         sub_sync <= 3'h0;
         lp_sync <= 2'h0;
      end else begin
         ev_sync <= {ev_sync[1:0], external_event_in};
         sub_sync <= {sub_sync[1:0], subclock_in};
         lp_sync <= {lp_sync[0], low_power_mode};
      end
   end

   // ****************************************************************
   // Clock source selection
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 3'h0;
      end else begin
         div_count <= div_count + 3'h1;
      end
   end

   always_comb begin
      if (timer_control[`CTRL_CKS_HI]) begin
         count_tick = ev_sync[1] && !ev_sync[2];
      end else if (timer_control[`CTRL_CKS_HI:`CTRL_CKS_LO] == tmr_pkg::SEL_DIV1 && lp_sync[1]) begin
         count_tick = sub_sync[1] && !sub_sync[2];
      end else begin
         count_tick = tick_of(timer_control[`CTRL_CKS_HI:`CTRL_CKS_LO], div_count);
      end
   end

   // ****************************************************************
   // Counter
   // ****************************************************************
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         match_now[i] = count_tick && (count_value == general_reg[i]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= `COUNT_ZERO;
      end else if (wr_en && paddr == `ADDR_COUNT) begin
         count_value <= pwdata[15:0];
      end else if (count_tick) begin
         if (timer_control[`CTRL_CLEAR_BIT] && match_now[0]) begin
            count_value <= `COUNT_ZERO;
         end else begin
            count_value <= count_value + 16'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            general_reg[i] <= `GENERAL_RESET;
         end
      end else if (wr_en && paddr >= `ADDR_GENERAL_A && paddr <= `ADDR_GENERAL_D) begin
         general_reg[paddr[3:2]] <= pwdata[15:0];
      end
   end

   // ****************************************************************
   // Control and enable registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control <= `CONTROL_RESET;
         timer_interrupt_enable <= `IE_RESET;
      end else if (wr_en) begin
         if (paddr == `ADDR_CONTROL) begin
            timer_control <= pwdata[7:0];
         end
         if (paddr == `ADDR_IRQ_ENABLE) begin
            timer_interrupt_enable <= pwdata[7:0] & ~`IE_RSVD_BITS;
         end
      end
   end

   // ****************************************************************
   // Status flags: set wins over clear
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_status <= 5'h00;
         flag_seen <= 5'h00;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if ((i == 4) ? (count_tick && count_value == `COUNT_MAX
                  && !(timer_control[`CTRL_CLEAR_BIT] && match_now[0]))
                  : match_now[i]) begin
               timer_status[i] <= 1'b1;
            end else if (wr_en && paddr == `ADDR_STATUS && flag_seen[i]
                  && !pwdata[(i == 4) ? `STAT_OVF_BIT : i]) begin
               timer_status[i] <= 1'b0;
            end
         end
         if (rd_en && paddr == `ADDR_STATUS) begin
            flag_seen <= timer_status;
         end else if (wr_en && paddr == `ADDR_STATUS) begin
            flag_seen <= 5'h00;
         end
      end
   end

   // ****************************************************************
   // Compare outputs
   // ****************************************************************
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!matched_once[i]) begin
            next_pin[i] = timer_control[i];
         end else begin
            next_pin[i] = compare_pin[i] ^ match_now[i];
         end
      end
      if (wr_en && paddr == `ADDR_CONTROL) begin
         next_pin = pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_pin <= 4'h0;
         matched_once <= 4'h0;
      end else begin
         compare_pin <= next_pin;
         matched_once <= matched_once | match_now;
      end
   end

   // ****************************************************************
   // Interrupt requests
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq <= 1'b0;
         match_irq <= 4'h0;
      end else begin
         overflow_irq <= timer_status[4] && timer_interrupt_enable[`IE_OVF_BIT];
         match_irq <= timer_status[3:0] & timer_interrupt_enable[3:0];
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   always_comb begin
      next_prdata = 32'h0;
      unique case (paddr)
         `ADDR_CONTROL: next_prdata[7:0] = timer_control;
         `ADDR_IRQ_ENABLE: next_prdata[7:0] = timer_interrupt_enable | `IE_RSVD_BITS;
         `ADDR_STATUS: next_prdata[7:0] = {timer_status[4], 3'h7, timer_status[3:0]};
         `ADDR_COUNT: next_prdata[15:0] = count_value;
         `ADDR_GENERAL_A, `ADDR_GENERAL_B, `ADDR_GENERAL_C, `ADDR_GENERAL_D:
            next_prdata[15:0] = general_reg[paddr[3:2]];
         default: next_prdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0;
      end
   end

   // ****************************************************************
   // Checks: interrupt gating, reserved bits, register reset and ready pulse
   // ****************************************************************
   ovf_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      overflow_irq == $past(timer_status[4] && timer_interrupt_enable[`IE_OVF_BIT]))
      else $error("overflow request not gated by enable");

   match_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_irq == $past(timer_status[3:0] & timer_interrupt_enable[3:0]))
      else $error("match request not gated by enable");

   ie_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_interrupt_enable & `IE_RSVD_BITS) == 8'h00)
      else $error("reserved enable bits stored");

   reset_clear_a: assert property (@(posedge pclk)
      !$past(presetn) |-> timer_control == `CONTROL_RESET
         && timer_interrupt_enable == `IE_RESET)
      else $error("control bits not cleared by reset");

   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held for more than one cycle");

   // ****************************************************************
   // Checks: counter and clock source
   // ****************************************************************
   clear_on_a_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_tick && match_now[0] && timer_control[`CTRL_CLEAR_BIT] && !wr_en
         |=> count_value == `COUNT_ZERO)
      else $error("counter not cleared on match A");

   wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_tick && count_value == `COUNT_MAX && !wr_en && !timer_control[`CTRL_CLEAR_BIT]
         |=> timer_status[4])
      else $error("overflow flag not set on wrap");

   match_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_now[0] |=> timer_status[0])
      else $error("match flag A not set");

   div1_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_control[`CTRL_CKS_HI:`CTRL_CKS_LO] == tmr_pkg::SEL_DIV1 && !lp_sync[1]
         |-> count_tick)
      else $error("undivided clock missed a tick");

   div8_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_control[`CTRL_CKS_HI:`CTRL_CKS_LO] == tmr_pkg::SEL_DIV8 && count_tick
         |=> !count_tick [*7])
      else $error("divide by eight ticks too often");

   event_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_control[`CTRL_CKS_HI] && count_tick |=> !count_tick)
      else $error("event select counted twice for one edge");

   sub_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_control[`CTRL_CKS_HI:`CTRL_CKS_LO] == tmr_pkg::SEL_DIV1 && lp_sync[1]
         && !sub_sync[1] |-> !count_tick)
      else $error("subclock mode counted without subclock edge");

   // ****************************************************************
   // Checks: status flags
   // ****************************************************************
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(timer_status[0]) |-> $past(wr_en && paddr == `ADDR_STATUS && flag_seen[0]))
      else $error("flag cleared without read then write");

   flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_status[4] && !(wr_en && paddr == `ADDR_STATUS) |=> timer_status[4])
      else $error("overflow flag dropped without a write");

   // ****************************************************************
   // Checks: compare outputs
   // ****************************************************************
   level_now_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `ADDR_CONTROL |=> compare_pin == $past(pwdata[3:0]))
      else $error("level write not reflected");

   level_hold_d_a: assert property (@(posedge pclk) disable iff (!presetn)
      !matched_once[3] && !(wr_en && paddr == `ADDR_CONTROL) |=> compare_pin[3] == timer_control[3])
      else $error("pin D left its level before a match");

   level_hold_c_a: assert property (@(posedge pclk) disable iff (!presetn)
      !matched_once[2] && !(wr_en && paddr == `ADDR_CONTROL) |=> compare_pin[2] == timer_control[2])
      else $error("pin C left its level before a match");

   level_hold_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      !matched_once[1] && !(wr_en && paddr == `ADDR_CONTROL) |=> compare_pin[1] == timer_control[1])
      else $error("pin B left its level before a match");

   level_hold_a_a: assert property (@(posedge pclk) disable iff (!presetn)
      !matched_once[0] && !(wr_en && paddr == `ADDR_CONTROL) |=> compare_pin[0] == timer_control[0])
      else $error("pin A left its level before a match");

   // ****************************************************************
   // Cover points
   // ****************************************************************
   sub_cov: cover property (@(posedge pclk) disable iff (!presetn) lp_sync[1] && count_tick);
   ovf_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(overflow_irq));
   match_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(match_irq[0]));
   clear_cov: cover property (@(posedge pclk) disable iff (!presetn) $fell(timer_status[0]));
   ext_cov: cover property (@(posedge pclk) disable iff (!presetn)
      timer_control[6] && count_tick);
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "tmr_regs.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic external_event_in, subclock_in, low_power_mode, overflow_irq, err;
   logic [3:0] compare_pin, match_irq;
   int n_fail = 0;
   int check_count = 0;
   timer_core u_timer_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_event_in(external_event_in), .subclock_in(subclock_in),
      .low_power_mode(low_power_mode), .compare_pin(compare_pin), .overflow_irq(overflow_irq),
      .match_irq(match_irq));
   // ************
   // Bus and pins
   // ************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic pulses(input logic sub, input int k);
      repeat (k) begin
         if (sub) subclock_in <= 1'b1; else external_event_in <= 1'b1;
         idle(4);
         if (sub) subclock_in <= 1'b0; else external_event_in <= 1'b0;
         idle(4);
      end
   endtask
   // ************
   // Scenarios
   // ************
   task automatic t_regs();
      apb(0, `ADDR_CONTROL, 0); `CHK("control reset", 32'h0, rd)
      apb(0, `ADDR_IRQ_ENABLE, 0); `CHK("enable reset", 32'h70, rd)
      apb(1, `ADDR_IRQ_ENABLE, 32'h0F); apb(0, `ADDR_IRQ_ENABLE, 0);
      `CHK("enable rsvd", 32'h7F, rd)
      apb(1, `ADDR_IRQ_ENABLE, 32'h00);
      apb(0, 12'h0FC, 0); `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      $display("regs done");
   endtask
   task automatic t_levels();
      logic [3:0] v [2] = '{4'hA, 4'h5};
      foreach (v[i]) begin
         apb(1, `ADDR_CONTROL, {28'h0, v[i]}); idle(1);
         `CHK("pins", v[i], compare_pin)
      end
      apb(1, `ADDR_CONTROL, 32'h0);
      $display("levels done");
   endtask
   task automatic t_divider();
      for (int s = 0; s < 4; s++) begin
         apb(1, `ADDR_CONTROL, s << 4); apb(1, `ADDR_COUNT, 0); idle(32);
         apb(0, `ADDR_COUNT, 0);
         `CHK("div count", 1'b1, (rd >= (30 >> s)) && (rd <= (36 >> s) + 1))
      end
      $display("divider done");
   endtask
   task automatic t_events();
      for (int x = 4; x < 8; x += 3) begin
         apb(1, `ADDR_CONTROL, x << 4); apb(1, `ADDR_COUNT, 0); pulses(0, 5); idle(4);
         apb(0, `ADDR_COUNT, 0); `CHK("event count", 32'h5, rd)
      end
      low_power_mode <= 1'b1;
      apb(1, `ADDR_CONTROL, 0); idle(4); apb(1, `ADDR_COUNT, 0); pulses(1, 3); idle(4);
      apb(0, `ADDR_COUNT, 0); `CHK("subclock count", 32'h3, rd)
      low_power_mode <= 1'b0;
      $display("events done");
   endtask
   task automatic t_overflow();
      apb(1, `ADDR_IRQ_ENABLE, 32'h80); apb(1, `ADDR_COUNT, 32'hFFFC); idle(8);
      apb(1, `ADDR_CONTROL, 32'h40); idle(3);
      `CHK("ovf irq", 1'b1, overflow_irq)
      apb(1, `ADDR_IRQ_ENABLE, 0); idle(3); `CHK("ovf masked", 1'b0, overflow_irq)
      apb(1, `ADDR_IRQ_ENABLE, 32'h80); apb(1, `ADDR_STATUS, 0); idle(3);
      `CHK("ovf no read", 1'b1, overflow_irq)
      apb(0, `ADDR_STATUS, 0); `CHK("ovf flag", 1'b1, rd[7])
      apb(1, `ADDR_STATUS, 0); idle(3); `CHK("ovf cleared", 1'b0, overflow_irq)
      $display("overflow done");
   endtask
   task automatic t_match();
      apb(1, `ADDR_IRQ_ENABLE, 0);
      apb(1, `ADDR_GENERAL_A, 32'h10); apb(1, `ADDR_GENERAL_B, 32'h08);
      apb(1, `ADDR_GENERAL_C, 32'h0C); apb(1, `ADDR_GENERAL_D, 32'h0E);
      apb(1, `ADDR_COUNT, 0); apb(1, `ADDR_CONTROL, 32'h80); apb(1, `ADDR_IRQ_ENABLE, 32'h0F);
      idle(40); `CHK("match irq", 4'hF, match_irq)
      apb(0, `ADDR_COUNT, 0); `CHK("clear on A", 1'b1, rd <= 32'h10)
      apb(1, `ADDR_IRQ_ENABLE, 0); idle(3); `CHK("match masked", 4'h0, match_irq)
      apb(1, `ADDR_CONTROL, 0); apb(1, `ADDR_COUNT, 0); idle(40);
      apb(0, `ADDR_COUNT, 0); `CHK("free run", 1'b1, rd > 32'h10)
      $display("match done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      idle(20000);
      n_fail++;
      wrap_up();
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      external_event_in = 1'b0; subclock_in = 1'b0; low_power_mode = 1'b0;
      idle(2);
      presetn <= 1'b1;
      t_regs();
      t_levels();
      t_divider();
      t_events();
      t_overflow();
      t_match();
      wrap_up();
   end
endmodule
